// file: rtl/sram_port_cfg.svh
// Constants for the pipelined synchronous SRAM control port
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH
`define ADDR_WIDTH_DEF  16
`define LANES_DEF       4
`define LANE_BITS_DEF   9
`define MAX_LANES       4
`define BURST_BITS      2
`define MEM_DEPTH_DEF   1024
`endif

// file: rtl/sram_port_pkg.sv
// Types for the pipelined synchronous SRAM control port
`include "sram_port_cfg.svh"
package sram_port_pkg;
	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_READ,
		ACC_WRITE
	} access_t;
	typedef logic [`BURST_BITS-1:0] burst_t;
endpackage : sram_port_pkg

// file: rtl/sync_sram_port.sv
// Pipelined synchronous burst SRAM: control port with memory array
`timescale 1ns/10ps
`include "sram_port_cfg.svh"
module sync_sram_port
	import sram_port_pkg::*;
#(
	parameter int ADDR_WIDTH = `ADDR_WIDTH_DEF,
	parameter int LANES      = `LANES_DEF,
	parameter int LANE_BITS  = `LANE_BITS_DEF,
	parameter int MEM_DEPTH  = `MEM_DEPTH_DEF
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// Address and strobes
	input  wire logic [ADDR_WIDTH-1:0]      address,
	input  wire logic                       cpu_addr_strobe_n,
	input  wire logic                       ctl_addr_strobe_n,
	input  wire logic                       burst_step_n,
	// Chip enables
	input  wire logic                       first_select_n,
	input  wire logic                       second_select,
	input  wire logic                       third_select_n,
	// Write controls
	input  wire logic                       all_byte_write_n,
	input  wire logic                       lane_write_gate_n,
	input  wire logic [`MAX_LANES-1:0]      lane_select_n,
	// Burst order strap and output enable
	input  wire logic                       order_strap,
	input  wire logic                       out_enable_n,
	// Data pins, split three ways
	input  wire logic [LANES*LANE_BITS-1:0] data_in,
	output logic      [LANES*LANE_BITS-1:0] data_out,
	output logic                            data_oe
);

	localparam int WORD = LANES * LANE_BITS;

	// One word per location; lanes are slices of it
	logic [WORD-1:0] mem [MEM_DEPTH];

	// Input capture stage
	logic [ADDR_WIDTH-1:0] in_addr_reg, in_addr_next;
	logic                  in_cpu_n_reg, in_cpu_n_next;
	logic                  in_ctl_n_reg, in_ctl_n_next;
	logic                  in_step_n_reg, in_step_n_next;
	logic                  in_first_n_reg, in_first_n_next;
	logic                  in_second_reg, in_second_next;
	logic                  in_third_n_reg, in_third_n_next;
	logic                  in_all_n_reg, in_all_n_next;
	logic                  in_gate_n_reg, in_gate_n_next;
	logic [LANES-1:0]      in_lane_n_reg, in_lane_n_next;
	logic [WORD-1:0]       in_data_reg, in_data_next;
	logic                  order_reg, order_next;
	logic                  valid_reg, valid_next;

	// Access stage
	logic [ADDR_WIDTH-1:0] base_reg, base_next;
	burst_t                count_reg, count_next;
	access_t               acc_reg, acc_next;
	logic                  sel_reg, sel_next;
	logic                  first_rd_reg, first_rd_next;
	logic [WORD-1:0]       dout_reg, dout_next;
	logic                  oe_reg, oe_next;

	// Interleaved order xors the step count into the seed
	function automatic burst_t burst_index(input burst_t seed, input burst_t step, input logic lin);
		burst_index = lin ? burst_t'(seed + step) : (seed ^ step);
	endfunction : burst_index

	function automatic logic [ADDR_WIDTH-1:0] word_addr(input logic [ADDR_WIDTH-1:0] a, input burst_t b);
		word_addr = {a[ADDR_WIDTH-1:`BURST_BITS], b};
	endfunction : word_addr

	// Address, strobes and enables
	always_comb begin
		in_addr_next   = address;
		in_cpu_n_next  = cpu_addr_strobe_n;
		in_ctl_n_next  = ctl_addr_strobe_n;
		in_step_n_next = burst_step_n;
		in_first_n_next  = first_select_n;
		in_second_next   = second_select;
		in_third_n_next  = third_select_n;
	end

	// Write controls, data and strap
	always_comb begin
		in_all_n_next  = all_byte_write_n;
		in_gate_n_next = lane_write_gate_n;
		in_lane_n_next = lane_select_n[LANES-1:0];
		in_data_next   = data_in;
		order_next     = order_strap;
		valid_next     = 1'b1;
	end

	// Input registers reset to the idle, deselected levels
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in_addr_reg   <= '0;
			in_cpu_n_reg  <= 1'b1;
			in_ctl_n_reg  <= 1'b1;
			in_step_n_reg <= 1'b1;
			in_first_n_reg <= 1'b1;
			in_second_reg  <= 1'b0;
			in_third_n_reg <= 1'b1;
		end else begin
			in_addr_reg    <= in_addr_next;
			in_cpu_n_reg   <= in_cpu_n_next;
			in_ctl_n_reg   <= in_ctl_n_next;
			in_step_n_reg  <= in_step_n_next;
			in_first_n_reg <= in_first_n_next;
			in_second_reg  <= in_second_next;
			in_third_n_reg <= in_third_n_next;
		end
	end

	// Write controls, data and strap
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in_all_n_reg  <= 1'b1;
			in_gate_n_reg <= 1'b1;
			in_lane_n_reg <= '1;
			in_data_reg   <= '0;
			order_reg     <= 1'b0;
			valid_reg     <= 1'b0;
		end else begin
			in_all_n_reg  <= in_all_n_next;
			in_gate_n_reg <= in_gate_n_next;
			in_lane_n_reg <= in_lane_n_next;
			in_data_reg   <= in_data_next;
			order_reg     <= order_next;
			valid_reg     <= valid_next;
		end
	end

	// All three enables must agree, each at its own active level
	function automatic logic chip_selected(input logic first_n, input logic second, input logic third_n);
		chip_selected = !first_n && second && !third_n;
	endfunction : chip_selected

	// Global write overrides the gate and every lane select
	function automatic logic [LANES-1:0] lane_enables(input logic all_n, input logic gate_n,
		input logic [LANES-1:0] lanes_n);
		for (int i = 0; i < LANES; i++) begin
			lane_enables[i] = !all_n || (!gate_n && !lanes_n[i]);
		end
	endfunction : lane_enables

	// Strobe decode on the registered inputs
	logic             cpu_take, ctl_take, strobe, selected, is_write;
	logic [LANES-1:0] lane_we;
	logic [ADDR_WIDTH-1:0] cur_addr;

	always_comb begin
		// A processor strobe with the first enable high starts nothing
		cpu_take = valid_reg && !in_cpu_n_reg && !in_first_n_reg;
		// The controller strobe only counts while the processor strobe is idle
		ctl_take = valid_reg && !in_ctl_n_reg && in_cpu_n_reg;
		strobe   = cpu_take || ctl_take;
		selected = chip_selected(in_first_n_reg, in_second_reg, in_third_n_reg);
		lane_we  = lane_enables(in_all_n_reg, in_gate_n_reg, in_lane_n_reg);
		// Processor strobe cycles are always reads; writes follow later
		is_write = |lane_we;
		cur_addr = word_addr(base_reg, burst_index(base_reg[`BURST_BITS-1:0], count_reg, !order_reg));
	end

	// Burst address group: loads on a selected strobe, otherwise steps or holds
	always_comb begin
		base_next  = base_reg;
		count_next = count_reg;
		if (strobe && selected) begin
			base_next  = in_addr_reg;
			count_next = '0;
		end else if (!strobe && sel_reg && !in_step_n_reg) begin
			// Stepping only runs while selected and no strobe is taken
			count_next = burst_t'(count_reg + 2'b01);
		end
	end

	// Access group: enables only matter on a strobe, never inside a burst
	always_comb begin
		acc_next      = acc_reg;
		sel_next      = sel_reg;
		first_rd_next = 1'b0;
		if (strobe) begin
			sel_next = selected;
			if (selected) begin
				acc_next      = (ctl_take && is_write) ? ACC_WRITE : ACC_READ;
				// Drive is masked on the first read out of a deselected state
				first_rd_next = !sel_reg && !(ctl_take && is_write);
			end else begin
				acc_next = ACC_IDLE;
			end
		end else if (sel_reg) begin
			acc_next = is_write ? ACC_WRITE : ACC_READ;
		end
	end

	// Write and read port of the array
	localparam int INDEX_BITS = $clog2(MEM_DEPTH);

	// Write path
	logic [ADDR_WIDTH-1:0] next_addr;
	logic                  wr_go;
	logic [INDEX_BITS-1:0] wr_index;
	logic [LANES-1:0]      wr_lanes;
	logic [WORD-1:0]       wr_word;
	logic [INDEX_BITS-1:0] rd_index;

	// Address bits above the array depth are ignored, so larger maps alias
	function automatic logic [INDEX_BITS-1:0] array_index(input logic [ADDR_WIDTH-1:0] a);
		array_index = a[INDEX_BITS-1:0];
	endfunction : array_index

	// The write lands at the address the access stage is about to hold
	always_comb begin
		next_addr = word_addr(base_next, burst_index(base_next[`BURST_BITS-1:0], count_next, !order_reg));
		wr_go     = sel_next && (acc_next == ACC_WRITE);
		// Data was captured on the same edge as the write controls
		wr_word   = in_data_reg;
		wr_lanes  = wr_go ? lane_we : '0;
		wr_index  = array_index(next_addr);
		// Reads follow the held burst address, one edge behind the capture
		rd_index  = array_index(cur_addr);
	end

	// No reset on the array: it is storage, and clearing it would cost a sweep
	always_ff @(posedge clock) begin
		for (int i = 0; i < LANES; i++) begin
			if (!rst && wr_lanes[i]) begin
				mem[wr_index][i*LANE_BITS +: LANE_BITS] <= wr_word[i*LANE_BITS +: LANE_BITS];
			end
		end
	end

	// Output stage
	always_comb begin
		// Data is read every cycle; only the drive decides whether it is seen
		dout_next = mem[rd_index];
		// Output enable is sampled with the clock here; one clock of lag is the cost
		oe_next   = !out_enable_n && sel_reg && acc_reg == ACC_READ && !first_rd_reg;
	end

	// Burst address registers; the counter wraps by its own width
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			base_reg  <= '0;
			count_reg <= '0;
		end else begin
			base_reg  <= base_next;
			count_reg <= count_next;
		end
	end

	// Access state registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_reg      <= ACC_IDLE;
			sel_reg      <= 1'b0;
			first_rd_reg <= 1'b0;
		end else begin
			acc_reg      <= acc_next;
			sel_reg      <= sel_next;
			first_rd_reg <= first_rd_next;
		end
	end

	// Output registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dout_reg <= '0;
			oe_reg   <= 1'b0;
		end else begin
			dout_reg <= dout_next;
			oe_reg   <= oe_next;
		end
	end

	// Pins come straight from the output flops
	assign data_out = dout_reg;
	assign data_oe  = oe_reg;

endmodule : sync_sram_port

// file: verif/sync_sram_port_sva.sv
// Pin-level assertions for the SRAM control port
`timescale 1ns/10ps
module sync_sram_port_sva #(
	parameter int LANES     = 4,
	parameter int LANE_BITS = 9
) (
	// Clock, reset and controls
	input wire logic clock, rst, cpu_addr_strobe_n, ctl_addr_strobe_n, burst_step_n, out_enable_n,
	input wire logic first_select_n, second_select, third_select_n, all_byte_write_n, lane_write_gate_n,
	// Read side
	input wire logic                       data_oe,
	input wire logic [LANES*LANE_BITS-1:0] data_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire sel   = !first_select_n && second_select && !third_select_n;
	wire nowr  = all_byte_write_n && lane_write_gate_n;
	wire quiet = cpu_addr_strobe_n && ctl_addr_strobe_n && nowr && !out_enable_n;
	sequence rd_go; !cpu_addr_strobe_n && sel && nowr; endsequence
	sequence desel; !ctl_addr_strobe_n && !sel; endsequence
	chk_oe_release: assert property (out_enable_n [*3] |-> !data_oe)
		else $error("pins driven while disabled");
	chk_oe_drive: assert property (rd_go ##1 rd_go ##0 (!out_enable_n ##1 quiet [*2]) |=> data_oe)
		else $error("read data not driven");
	chk_first_mask: assert property (desel ##1 rd_go |-> ##3 !data_oe)
		else $error("first read after deselect driven");
	chk_ce1_off: assert property (!ctl_addr_strobe_n && first_select_n |-> ##3 !data_oe)
		else $error("selected with first enable high");
	chk_ce2_off: assert property (!ctl_addr_strobe_n && !second_select |-> ##3 !data_oe)
		else $error("selected with second enable low");
	chk_ce3_off: assert property (!ctl_addr_strobe_n && third_select_n |-> ##3 !data_oe)
		else $error("selected with third enable high");
	chk_hold_data: assert property ((ctl_addr_strobe_n && burst_step_n && nowr
		&& (cpu_addr_strobe_n || first_select_n)) [*4] |-> $stable(data_out)) else $error("data moved");
	chk_burst_keep: assert property (quiet [*3] ##0 data_oe |=> data_oe)
		else $error("drive lost in burst");
endmodule : sync_sram_port_sva
bind sync_sram_port sync_sram_port_sva #(.LANES(LANES), .LANE_BITS(LANE_BITS)) sync_sram_port_sva_inst (.*);

// file: verif/sram_master.sv
// Bus master model driving the SRAM control port
`timescale 1ns/10ps
module sram_master (
	// Clock
	input  wire logic   clock,
	// Address, strobes, enables, write controls
	output logic [15:0] address,
	output logic        cpu_addr_strobe_n, ctl_addr_strobe_n, burst_step_n, first_select_n, second_select,
	output logic        third_select_n, all_byte_write_n, lane_write_gate_n, out_enable_n,
	output logic [3:0]  lane_select_n,
	// Write data onto the shared pins
	output logic [17:0] wd
);
	task automatic set(input logic [8:0] k, input logic [15:0] a, input logic [17:0] d, input logic [3:0] ls);
		{cpu_addr_strobe_n, ctl_addr_strobe_n, burst_step_n, first_select_n, second_select, third_select_n,
			all_byte_write_n, lane_write_gate_n, out_enable_n} = k;
		lane_select_n = ls;
		address = a;
		// Released lines must not keep the last value
		wd = (k[2] && k[1]) ? ~wd : d;
	endtask : set
	task automatic cyc(input logic [8:0] k, input logic [15:0] a = 16'h0000, input logic [17:0] d = 18'h00000,
		input logic [3:0] ls = 4'hf);
		set(k, a, d, ls);
		@(posedge clock);
		#1;
	endtask : cyc
	initial begin
		wd = 18'h00000;
		set(9'h1d6, 16'h0000, 18'h00000, 4'hf);
	end
endmodule : sram_master

// file: verif/sync_sram_port_bench.sv
// Self-checking bench for the SRAM control port
`timescale 1ns/10ps
module sync_sram_port_bench;
	logic        clock = 1'b0, rst = 1'b1, order_strap = 1'b0, data_oe;
	logic [15:0] address;
	logic        cpu_addr_strobe_n, ctl_addr_strobe_n, burst_step_n, first_select_n, second_select;
	logic        third_select_n, all_byte_write_n, lane_write_gate_n, out_enable_n;
	logic [3:0]  lane_select_n;
	logic [17:0] wd, data_in, data_out, exp_m [16];
	int          bad_count = 0, tests_run = 0;
	assign data_in = data_oe ? data_out : wd;
	always #12.5 clock = ~clock;
	sram_master m (.*);
	sync_sram_port #(.LANES(2)) sync_sram_port_inst (.*);
	task automatic chk(input logic [17:0] e);
		tests_run++;
		if (data_out !== e) begin
			bad_count++;
			$display("ERROR %0t data %h want %h", $time, data_out, e);
		end
	endtask : chk
	task automatic flag(input logic e);
		tests_run++;
		if (data_oe !== e) begin
			bad_count++;
			$display("ERROR %0t drive %b", $time, data_oe);
		end
	endtask : flag
	task automatic rd(input logic [15:0] a, input logic [17:0] e);
		m.cyc(9'h0d6, a);
		repeat (2) m.cyc(9'h1d6);
		chk(e);
	endtask : rd
	task automatic t_burst(input logic md, input logic [1:0] s);
		logic [1:0] o;
		rst = 1'b1;
		order_strap = md;
		repeat (10) @(posedge clock);
		#1 rst = 1'b0;
		for (int i = 0; i < 16; i++) begin
			exp_m[i] = 18'h1c300 + 18'(i);
			m.cyc(9'h153, 16'(i), exp_m[i], 4'(i));
		end
		for (int j = 0; j < 7; j++) begin
			m.cyc(j == 0 ? 9'h0d6 : j < 4 ? 9'h1ae : 9'h1d6, 16'h000c | 16'(s));
			o = md ? s ^ 2'(j > 5 ? 3 : j - 2) : s + 2'(j > 5 ? 3 : j - 2);
			if (j > 1) chk(exp_m[{2'h3, o}]);
		end
	endtask : t_burst
	task automatic t_basic;
		for (int i = 0; i < 18; i++) begin
			m.cyc(i < 16 ? 9'h0d6 : 9'h1d6, 16'(i));
			if (i > 1) chk(exp_m[i-2]);
		end
		flag(1'b1);
		repeat (3) m.cyc(9'h1d7);
		flag(1'b0);
	endtask : t_basic
	task automatic t_other;
		logic [8:0] dk [3] = '{9'h176, 9'h146, 9'h15e};
		m.cyc(9'h153, 16'h0020, 18'h3ffff);
		m.cyc(9'h155, 16'h0020, 18'h00000, 4'he);
		m.cyc(9'h157, 16'h0020, 18'h00000, 4'h0);
		m.cyc(9'h155, 16'h0020, 18'h00000, 4'h3);
		rd(16'h0020, 18'h3fe00);
		m.cyc(9'h053, 16'h0004);
		rd(16'h0004, exp_m[4]);
		m.cyc(9'h0f6, 16'h0005);
		repeat (2) m.cyc(9'h1d6);
		chk(exp_m[4]);
		flag(1'b1);
		for (int e = 0; e < 3; e++) begin
			m.cyc(dk[e]);
			rd(16'(e), exp_m[e]);
			flag(1'b0);
			m.cyc(9'h1d6);
			flag(1'b1);
		end
	endtask : t_other
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		t_burst(1'b0, 2'h3);
		t_basic;
		t_other;
		t_burst(1'b1, 2'h1);
		tally_and_finish;
	end
	initial begin
		#20us;
		bad_count++;
		tally_and_finish;
	end
endmodule : sync_sram_port_bench
